// ===== rtl/port_ctl.sv
// root hub port reset, suspend and overcurrent logic with ahb-lite registers
// assumes synchronous port pins and a single-master ahb-lite bus
//
// Overview of operation
// - write 1 bit4 starts reset signalling
// - reset end sets change flag, clears status
// - written zero on reset bit does nothing
// - reset with no device sets connect indication
// - overcurrent bit meaningful only per-port mode
// - overcurrent reads zero without per-port mode
// - overcurrent reads one during overcurrent
// - write 1 bit3 starts resume
// - resume only while suspended
// - suspend set by write, held through resume
// - resume end sets change, clears suspend
// - suspend never set without device
// - reset completion clears suspend
// - global resume clears suspend
// - upstream resume propagates to host
// - suspend with no device sets connect indication
// - attached bit mirrors device presence
// - reset completion sets port enabled
`timescale 1ns/1ps
`default_nettype none
module port_ctl
  import port_ctl_pkg::*;
#(
  parameter int RESET_LEN = port_ctl_pkg::RESET_CYCLES,
  parameter int RESUME_LEN = port_ctl_pkg::RESUME_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // port side
  input wire logic device_present,
  input wire logic overcurrent_in,
  input wire logic upstream_resume_in,
  input wire logic global_resume_state,
  output logic port_reset_drive,
  output logic port_resume_drive,
  output logic resume_to_host,
  // interrupt
  output logic irq
);
  import port_ctl_pkg::*;

  initial begin
    if (RESET_LEN < 1 || RESET_LEN >= (1 << TMR_W) ||
        RESUME_LEN < 1 || RESUME_LEN >= (1 << TMR_W)) begin
      $error("port_ctl interval out of timer range");
    end
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rd_go;
  logic [31:0] rd_data;

  // zero-wait slave; write lands one cycle after its address phase
  assign rd_go = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  function automatic logic wr_hit(input logic [7:0] off, input logic pend,
                                  input logic [7:0] a);
    return pend && (a == off);
  endfunction

  logic wr_port;
  logic wr_irq;
  logic wr_mask;
  logic wr_cfg;
  assign wr_port = wr_hit(OFF_PORT_STATUS, wr_pend_r, wr_addr_r);
  assign wr_irq = wr_hit(OFF_IRQ_STATUS, wr_pend_r, wr_addr_r);
  assign wr_mask = wr_hit(OFF_IRQ_MASK, wr_pend_r, wr_addr_r);
  assign wr_cfg = wr_hit(OFF_CONFIG, wr_pend_r, wr_addr_r);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= rd_go ? rd_data : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // port state
  // ----------------------------------------
  logic attached_r;
  logic enabled_r;
  logic suspended_r;
  logic reset_active_r;
  logic overcurrent_r;
  logic [31:0] cfg_r;
  logic [NUM_EVENTS-1:0] irq_stat_r;
  logic [NUM_EVENTS-1:0] irq_mask_r;
  tmr_mode_t mode_r;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_start;
  logic [TMR_W-1:0] tmr_load;
  logic cmd_reset;
  logic cmd_resume;
  logic cmd_suspend;
  logic reset_done;
  logic resume_done;
  logic ev_connect;
  logic ev_upresume;

  assign cmd_reset = wr_port && hwdata[BIT_RESET];
  assign cmd_resume = wr_port && hwdata[BIT_OVERCURRENT] && suspended_r
                      && mode_r == TMR_IDLE;
  assign cmd_suspend = wr_port && hwdata[BIT_SUSPENDED];
  assign reset_done = tmr_done && mode_r == TMR_RESET;
  assign resume_done = tmr_done && mode_r == TMR_RESUME;
  assign ev_connect = !attached_r && (cmd_reset || cmd_suspend);
  assign ev_upresume = suspended_r && upstream_resume_in;
  assign tmr_start = (cmd_reset && attached_r && !reset_active_r) || cmd_resume;
  assign tmr_load = (cmd_reset && attached_r) ? TMR_W'(RESET_LEN) : TMR_W'(RESUME_LEN);

  port_timer #(.WIDTH(TMR_W)) u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .start(tmr_start),
    .abort(global_resume_state && mode_r == TMR_RESUME),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_r <= TMR_IDLE;
    end else if (cmd_reset && attached_r && !reset_active_r) begin
      mode_r <= TMR_RESET;
    end else if (cmd_resume) begin
      mode_r <= TMR_RESUME;
    end else if (tmr_done || (global_resume_state && mode_r == TMR_RESUME)) begin
      mode_r <= TMR_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      attached_r <= 1'b0;
    end else begin
      attached_r <= device_present;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reset_active_r <= 1'b0;
    end else if (reset_done) begin
      reset_active_r <= 1'b0;
    end else if (cmd_reset && attached_r) begin
      reset_active_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      enabled_r <= 1'b0;
    end else if (!attached_r) begin
      enabled_r <= 1'b0;
    end else if (reset_done) begin
      enabled_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      suspended_r <= 1'b0;
    end else if (reset_done || resume_done) begin
      suspended_r <= 1'b0;
    end else if (global_resume_state || !attached_r) begin
      suspended_r <= 1'b0;
    end else if (cmd_suspend) begin
      suspended_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      overcurrent_r <= 1'b0;
    end else begin
      overcurrent_r <= cfg_r[CFG_PER_PORT_OC] && overcurrent_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_r <= CONFIG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= {31'h0000_0000, hwdata[CFG_PER_PORT_OC]};
    end
  end

  // ----------------------------------------
  // port pins
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      port_reset_drive <= 1'b0;
      port_resume_drive <= 1'b0;
      resume_to_host <= 1'b0;
    end else begin
      port_reset_drive <= tmr_busy && mode_r == TMR_RESET;
      port_resume_drive <= tmr_busy && mode_r == TMR_RESUME;
      resume_to_host <= ev_upresume;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [NUM_EVENTS-1:0] ev_vec;
  assign ev_vec = {ev_upresume, resume_done, reset_done, ev_connect};

  // set beats a same-cycle write-one clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_irq ? hwdata[NUM_EVENTS-1:0] : '0)) | ev_vec;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_mask_r <= MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_r <= hwdata[NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_PORT_STATUS: begin
        rd_data[BIT_ATTACHED] = attached_r;
        rd_data[BIT_ENABLED] = enabled_r;
        rd_data[BIT_SUSPENDED] = suspended_r;
        rd_data[BIT_OVERCURRENT] = overcurrent_r;
        rd_data[BIT_RESET] = reset_active_r;
      end
      OFF_IRQ_STATUS: rd_data[NUM_EVENTS-1:0] = irq_stat_r;
      OFF_IRQ_MASK: rd_data[NUM_EVENTS-1:0] = irq_mask_r;
      OFF_CONFIG: rd_data = cfg_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  reset_sets_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_reset && attached_r |=> reset_active_r)
    else $error("reset write did not set reset status");
  reset_end_a: assert property (@(posedge core_clk) disable iff (srst)
    reset_done |=> !reset_active_r && irq_stat_r[EV_RESET_DONE] && enabled_r)
    else $error("reset end mishandled");
  zero_write_a: assert property (@(posedge core_clk) disable iff (srst)
    wr_port && hwdata[4:2] == 3'h0 && !tmr_done && !global_resume_state
    && attached_r && device_present |=> $stable(reset_active_r) && $stable(suspended_r))
    else $error("zero write changed port state");
  no_dev_reset_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_reset && !attached_r |=> !reset_active_r && irq_stat_r[EV_CONNECT_IND])
    else $error("reset of absent port");
  oc_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    !cfg_r[CFG_PER_PORT_OC] |=> !overcurrent_r)
    else $error("overcurrent shown without per-port mode");
  suspend_dev_a: assert property (@(posedge core_clk) disable iff (srst)
    !attached_r |=> !suspended_r)
    else $error("suspend without device");
  resume_end_a: assert property (@(posedge core_clk) disable iff (srst)
    resume_done |=> !suspended_r ##0 irq_stat_r[EV_SUSPEND_DONE])
    else $error("resume end mishandled");
  reset_len_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(port_reset_drive) |-> port_reset_drive [*2])
    else $error("reset pulse too short");
  upresume_a: assert property (@(posedge core_clk) disable iff (srst)
    suspended_r && upstream_resume_in |=> resume_to_host)
    else $error("upstream resume lost");
endmodule
`default_nettype wire

// ===== common/port_ctl_pkg.sv
// constants for the root hub port reset / suspend block
// assumes a 100 MHz core clock and a 32-bit ahb-lite register bus
package port_ctl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PORT_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  // port status field positions
  localparam int BIT_ATTACHED = 0;
  localparam int BIT_ENABLED = 1;
  localparam int BIT_SUSPENDED = 2;
  localparam int BIT_OVERCURRENT = 3;
  localparam int BIT_RESET = 4;
  // irq status field positions
  localparam int EV_CONNECT_IND = 0;
  localparam int EV_RESET_DONE = 1;
  localparam int EV_SUSPEND_DONE = 2;
  localparam int EV_UPSTREAM_RESUME = 3;
  localparam int NUM_EVENTS = 4;
  // config field positions
  localparam int CFG_PER_PORT_OC = 0;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET = 4'h0;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RESET_TIME_US = 10000;
  localparam int RESUME_TIME_US = 20000;
  localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
  localparam int RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;
  localparam int TMR_W = 24;
  // interval timer modes
  typedef enum logic [1:0] {TMR_IDLE, TMR_RESET, TMR_RESUME} tmr_mode_t;
endpackage

// ===== rtl/port_timer.sv
// interval counter for reset and resume signalling
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module port_timer #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH-1:0] load,
  // status
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;

  initial begin
    if (WIDTH < 2) begin
      $error("port_timer width too small");
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && cnt_r <= WIDTH'(1)) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt_r <= busy ? cnt_r - WIDTH'(1) : cnt_r;
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/usb_dev_model.sv
// downstream device stand-in for the root hub port
// assumes the bench asks for attach, overcurrent and wake
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model (
  // clock
  input wire logic core_clk,
  // bench requests
  input wire logic attach,
  input wire logic oc,
  input wire logic wake,
  // port pins
  input wire logic port_reset_drive,
  output logic device_present,
  output logic overcurrent_in,
  output logic upstream_resume_in
);
  // a device held in reset cannot signal resume
  always_ff @(posedge core_clk) begin
    device_present <= attach;
    overcurrent_in <= oc;
    upstream_resume_in <= wake && attach && !port_reset_drive;
  end
endmodule
`default_nettype wire

// ===== tb/port_ctl_tb.sv
// self-checking bench for port_ctl
// assumes one ahb-lite slave, so hready is its own hreadyout
`timescale 1ns/1ps
`default_nettype none
module port_ctl_tb;
  import port_ctl_pkg::*;
  typedef struct {logic k; logic [31:0] m; logic [31:0] e;} note_t;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic gres = 1'b0;
  logic attach = 1'b0;
  logic oc = 1'b0;
  logic wake = 1'b0;
  logic smp = 1'b0;
  logic dph = 1'b0;
  logic hready, hreadyout, hresp, irq;
  logic [31:0] hrdata;
  logic dev_on, oc_in, up_res, rst_drv, res_drv, res_host;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  note_t q[$];
  note_t nt;
  assign hready = hreadyout;
  // short counts keep the run brief
  port_ctl #(.RESET_LEN(20), .RESUME_LEN(20)) port_ctl_inst (
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .device_present(dev_on), .overcurrent_in(oc_in),
    .upstream_resume_in(up_res), .global_resume_state(gres), .port_reset_drive(rst_drv),
    .port_resume_drive(res_drv), .resume_to_host(res_host), .irq(irq));
  usb_dev_model usb_dev_model_inst (
    .core_clk(core_clk), .attach(attach), .oc(oc), .wake(wake),
    .port_reset_drive(rst_drv), .device_present(dev_on), .overcurrent_in(oc_in),
    .upstream_resume_in(up_res));
  initial forever #5 core_clk = ~core_clk;
  // ---------------------------------------------
  // checking and bus cycles
  // ---------------------------------------------
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  // results appear at a read's data phase end or at a pin sample
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end else begin
      if ((dph && hreadyout === 1'b1) || smp) begin
        nt = q.pop_front();
        if (nt.k) begin
          check("pins", {28'h0, irq, res_host, res_drv, rst_drv} & nt.m, nt.e);
        end else begin
          check("hrdata", hrdata, nt.e);
          check("hresp", {31'h0, hresp}, 32'h0);
        end
      end
      if (hready === 1'b1) dph <= hsel && htrans[1] && !hwrite;
    end
  end
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back('{1'b0, 32'hFFFFFFFF, e});
    bus(a, 1'b0, 32'h0);
  endtask
  // first edge lets a just-written register reach the pins
  task automatic pins(input logic [3:0] m, input logic [3:0] e);
    q.push_back('{1'b1, {28'h0, m}, {28'h0, e}});
    @(posedge core_clk);
    smp <= 1'b1;
    @(posedge core_clk);
    smp <= 1'b0;
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    logic [3:0] m;
    m = 4'($urandom(32'hD0443925));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(OFF_PORT_STATUS, 32'h0);
    rd(OFF_IRQ_STATUS, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0);
    rd(OFF_CONFIG, CONFIG_RESET);
    wr(8'h20, $urandom);
    rd(8'h20, 32'h0);
    done("registers");
    wr(OFF_PORT_STATUS, 32'h10);
    wr(OFF_PORT_STATUS, 32'h04);
    rd(OFF_PORT_STATUS, 32'h0);
    rd(OFF_IRQ_STATUS, 32'h1);
    pins(4'h8, 4'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    pins(4'h8, 4'h8);
    wr(OFF_IRQ_STATUS, 32'h1);
    pins(4'h8, 4'h0);
    done("empty port");
    attach <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h1);
    wr(OFF_PORT_STATUS, 32'h0);
    wr(OFF_PORT_STATUS, 32'h8);
    pins(4'h7, 4'h0);
    rd(OFF_PORT_STATUS, 32'h1);
    rd(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_PORT_STATUS, 32'h10);
    pins(4'h1, 4'h1);
    rd(OFF_PORT_STATUS, 32'h11);
    repeat (30) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h3);
    rd(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_IRQ_STATUS, 32'h2);
    done("port reset");
    wr(OFF_PORT_STATUS, 32'h4);
    rd(OFF_PORT_STATUS, 32'h7);
    wr(OFF_PORT_STATUS, 32'h8);
    pins(4'h3, 4'h2);
    rd(OFF_PORT_STATUS, 32'h7);
    repeat (30) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h3);
    rd(OFF_IRQ_STATUS, 32'h4);
    wr(OFF_IRQ_STATUS, 32'h4);
    wr(OFF_PORT_STATUS, 32'h4);
    wr(OFF_PORT_STATUS, 32'h10);
    repeat (30) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h3);
    wr(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_PORT_STATUS, 32'h4);
    repeat (2) @(posedge core_clk);
    gres <= 1'b1;
    @(posedge core_clk);
    gres <= 1'b0;
    rd(OFF_PORT_STATUS, 32'h3);
    wr(OFF_PORT_STATUS, 32'h4);
    wr(OFF_PORT_STATUS, 32'h8);
    gres <= 1'b1;
    @(posedge core_clk);
    gres <= 1'b0;
    pins(4'h2, 4'h0);
    rd(OFF_PORT_STATUS, 32'h3);
    rd(OFF_IRQ_STATUS, 32'h0);
    done("suspend");
    wr(OFF_PORT_STATUS, 32'h4);
    repeat (2) @(posedge core_clk);
    wake <= 1'b1;
    repeat (3) @(posedge core_clk);
    pins(4'h4, 4'h4);
    rd(OFF_IRQ_STATUS, 32'h8);
    wake <= 1'b0;
    repeat (40) @(posedge core_clk);
    wr(OFF_IRQ_STATUS, 32'hF);
    attach <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(OFF_PORT_STATUS, 32'h14);
    rd(OFF_PORT_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m = 4'($urandom);
      wr(OFF_IRQ_MASK, {28'h0, m});
      rd(OFF_IRQ_MASK, {28'h0, m});
      pins(4'h8, {m[0], 3'h0});
    end
    done("wakeup and mask");
    oc <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h0);
    wr(OFF_CONFIG, 32'h1);
    rd(OFF_PORT_STATUS, 32'h8);
    oc <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(OFF_PORT_STATUS, 32'h0);
    done("overcurrent");
    finish_test();
  end
endmodule
`default_nettype wire
